// ==== bod_decoder.v ====
// Instruction decoder for the byte-operation core: fields, operations, flags and cycles.
`timescale 1ns/1ps
`default_nettype none
`include "bod_defs.vh"
module bod_decoder (
    input wire clk,
    input wire rstn,
    input wire [15:0] instr_word,
    input wire skip_true,
    output reg cycle_en,
    output reg [1:0] phase,
    output reg [15:0] instr_reg,
    output reg exec_nop,
    output reg second_word,
    output reg [5:0] byte_opcode,
    output reg dest_file,
    output reg access_banked,
    output reg [7:0] file_addr,
    output reg [2:0] bit_num,
    output reg [7:0] bit_mask,
    output reg [7:0] literal,
    output reg [19:0] jump_target,
    output reg [11:0] move_src,
    output reg [11:0] move_dst,
    output reg [10:0] branch_offset,
    output reg fast_mode,
    output reg table_op,
    output reg table_write,
    output reg [1:0] table_mode,
    output reg [5:0] alu_op,
    output reg [4:0] flag_mask,
    output reg is_skip,
    output reg [1:0] cycle_count
);
    // Decoded operation codes.
    localparam OP_NONE = 6'd0, OP_ADD = 6'd1, OP_ADDC = 6'd2, OP_SUB = 6'd3;
    localparam OP_SUBB = 6'd4, OP_RSUBB = 6'd5, OP_AND = 6'd6, OP_OR = 6'd7;
    localparam OP_XOR = 6'd8, OP_COM = 6'd9, OP_CPEQ = 6'd10, OP_CPGT = 6'd11;
    localparam OP_CPLT = 6'd12, OP_CLR = 6'd13, OP_SET = 6'd14, OP_NEG = 6'd15;
    localparam OP_STW = 6'd16, OP_TSTZ = 6'd17, OP_MUL = 6'd18, OP_DEC = 6'd19;
    localparam OP_INC = 6'd20, OP_DECSZ = 6'd21, OP_DECSNZ = 6'd22, OP_INCSZ = 6'd23;
    localparam OP_INCSNZ = 6'd24, OP_RLC = 6'd25, OP_RL = 6'd26, OP_RRC = 6'd27;
    localparam OP_RR = 6'd28, OP_SWAP = 6'd29, OP_MOV = 6'd30, OP_FILE_TO_FILE_MOVE = 6'd31;
    localparam OP_GOTO = 6'd32, OP_CALL = 6'd33, OP_BRA = 6'd34, OP_TABLE = 6'd35;
    localparam OP_RET = 6'd36, OP_LFSR = 6'd37;

    // Sequencer states: first word of an instruction or pending second word.
    localparam ST_FIRST = 1'b0, ST_SECOND = 1'b1;

    reg [1:0] phase_next;
    reg state_reg;
    reg state_next;
    reg [5:0] op_c;
    reg [4:0] fm_c;
    reg sk_c;
    reg two_word_c;
    reg [15:0] w;

    // Oscillator period counter; one instruction cycle is four clocks.
    always @* begin
        phase_next = (phase == 2'd3) ? 2'd0 : phase + 2'd1;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= 2'd0;
            cycle_en <= 1'b0;
        end else begin
            phase <= phase_next;
            cycle_en <= (phase == 2'd3);
        end
    end

    // Operation decode over the byte-oriented map plus two-word and control forms.
    always @* begin
        w = instr_word;
        op_c = OP_NONE;
        fm_c = `BOD_FLAGS_NONE;
        sk_c = 1'b0;
        two_word_c = 1'b0;
        case (w[15:12])
            4'h0: begin
                if (w[11:10] == 2'b01) begin
                    op_c = OP_DEC;
                    fm_c = `BOD_FLAGS_ALL;
                end else if (w[11:9] == 3'b001) begin
                    op_c = OP_MUL;
                end else if (w[15:4] == `BOD_TABLE_OP && w[3]) begin
                    op_c = OP_TABLE;
                end else if (w[15:1] == `BOD_RETURN_OP) begin
                    op_c = OP_RET;
                end
            end
            4'h1: begin
                fm_c = `BOD_FLAGS_ZN;
                case (w[11:10])
                    2'b00: op_c = OP_OR;
                    2'b01: op_c = OP_AND;
                    2'b10: op_c = OP_XOR;
                    default: op_c = OP_COM;
                endcase
            end
            4'h2: begin
                case (w[11:10])
                    2'b00: op_c = OP_ADDC;
                    2'b01: op_c = OP_ADD;
                    2'b10: op_c = OP_INC;
                    default: op_c = OP_DECSZ;
                endcase
                sk_c = (w[11:10] == 2'b11);
                fm_c = sk_c ? `BOD_FLAGS_NONE : `BOD_FLAGS_ALL;
            end
            4'h3: begin
                case (w[11:10])
                    2'b00: begin
                        op_c = OP_RRC;
                        fm_c = `BOD_FLAGS_CZN;
                    end
                    2'b01: begin
                        op_c = OP_RLC;
                        fm_c = `BOD_FLAGS_CZN;
                    end
                    2'b10: op_c = OP_SWAP;
                    default: begin
                        op_c = OP_INCSZ;
                        sk_c = 1'b1;
                    end
                endcase
            end
            4'h4: begin
                case (w[11:10])
                    2'b00: begin
                        op_c = OP_RR;
                        fm_c = `BOD_FLAGS_ZN;
                    end
                    2'b01: begin
                        op_c = OP_RL;
                        fm_c = `BOD_FLAGS_ZN;
                    end
                    2'b10: begin
                        op_c = OP_INCSNZ;
                        sk_c = 1'b1;
                    end
                    default: begin
                        op_c = OP_DECSNZ;
                        sk_c = 1'b1;
                    end
                endcase
            end
            4'h5: begin
                fm_c = `BOD_FLAGS_ALL;
                case (w[11:10])
                    2'b00: begin
                        op_c = OP_MOV;
                        fm_c = `BOD_FLAGS_ZN;
                    end
                    2'b01: op_c = OP_RSUBB;
                    2'b10: op_c = OP_SUBB;
                    default: op_c = OP_SUB;
                endcase
            end
            4'h6: begin
                case (w[11:9])
                    3'b000: op_c = OP_CPLT;
                    3'b001: op_c = OP_CPEQ;
                    3'b010: op_c = OP_CPGT;
                    3'b011: op_c = OP_TSTZ;
                    3'b100: op_c = OP_SET;
                    3'b101: begin
                        op_c = OP_CLR;
                        fm_c = `BOD_FLAGS_Z;
                    end
                    3'b110: begin
                        op_c = OP_NEG;
                        fm_c = `BOD_FLAGS_ALL;
                    end
                    default: op_c = OP_STW;
                endcase
                sk_c = (w[11:9] <= 3'b011);
            end
            4'hC: begin
                op_c = OP_FILE_TO_FILE_MOVE;
                two_word_c = 1'b1;
            end
            4'hD: begin
                if (w[15:11] == `BOD_RBRANCH_OP) op_c = OP_BRA;
            end
            4'hE: begin
                if (w[15:8] == `BOD_GOTO_OP) begin
                    op_c = OP_GOTO;
                    two_word_c = 1'b1;
                end else if (w[15:9] == `BOD_CALL_OP) begin
                    op_c = OP_CALL;
                    two_word_c = 1'b1;
                end else if (w[15:6] == `BOD_LFSR_OP) begin
                    // The pointer-load literal is the fourth two-word form.
                    op_c = OP_LFSR;
                    two_word_c = 1'b1;
                end
            end
            default: op_c = OP_NONE; // Bit, literal and other words decode as none.
        endcase
    end

    // Latch one instruction per cycle; a second word is absorbed, not executed.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_FIRST;
            instr_reg <= 16'h0000;
            exec_nop <= 1'b1;
            second_word <= 1'b0;
            byte_opcode <= 6'h00;
            dest_file <= 1'b0;
            access_banked <= 1'b0;
            file_addr <= 8'h00;
            bit_num <= 3'h0;
            bit_mask <= 8'h00;
            literal <= 8'h00;
            jump_target <= 20'h0_0000;
            move_src <= 12'h000;
            move_dst <= 12'h000;
            branch_offset <= 11'h000;
            fast_mode <= 1'b0;
            table_op <= 1'b0;
            table_write <= 1'b0;
            table_mode <= 2'h0;
            alu_op <= 6'h00;
            flag_mask <= 5'h00;
            is_skip <= 1'b0;
            cycle_count <= 2'd1;
        end else if (cycle_en) begin
            state_reg <= state_next;
            instr_reg <= instr_word;
            second_word <= (state_reg == ST_SECOND);
            if (state_reg == ST_SECOND) begin
                // Second word fills in the upper target or destination only.
                jump_target[19:8] <= instr_word[11:0];
                move_dst <= instr_word[11:0];
                exec_nop <= 1'b1;
                alu_op <= OP_NONE;
                flag_mask <= `BOD_FLAGS_NONE;
                is_skip <= 1'b0;
            end else begin
                // A lone 1111 word matches no opcode and runs as no-operation.
                exec_nop <= (op_c == OP_NONE);
                byte_opcode <= instr_word[15:10];
                dest_file <= instr_word[9];
                access_banked <= instr_word[8];
                file_addr <= instr_word[7:0];
                bit_num <= instr_word[11:9];
                bit_mask <= 8'h01 << instr_word[11:9];
                literal <= instr_word[7:0];
                jump_target[7:0] <= instr_word[7:0];
                move_src <= instr_word[11:0];
                branch_offset <= instr_word[10:0];
                fast_mode <= (op_c == OP_CALL) ? instr_word[8] :
                             (op_c == OP_RET) ? instr_word[0] : 1'b0;
                table_op <= (op_c == OP_TABLE);
                table_write <= instr_word[2];
                table_mode <= instr_word[1:0];
                alu_op <= op_c;
                flag_mask <= fm_c;
                is_skip <= sk_c;
                // Branches, jumps, returns and table ops change flow or need two cycles.
                cycle_count <= (two_word_c || op_c == OP_BRA || op_c == OP_RET ||
                                op_c == OP_TABLE) ? 2'd2 : 2'd1;
            end
        end else if (is_skip && skip_true && phase == 2'd1) begin
            cycle_count <= 2'd2;
        end
    end

    // A two-word first word arms the second-word state for the next cycle.
    always @* begin
        case (state_reg)
            ST_FIRST: state_next = two_word_c ? ST_SECOND : ST_FIRST;
            ST_SECOND: state_next = ST_FIRST;
            default: state_next = ST_FIRST;
        endcase
    end
endmodule // bod_decoder
`default_nettype wire

// ==== bod_decoder_checker.sv ====
// Concurrent checks on the decoder's ports.
`timescale 1ns/1ps
`default_nettype none
module bod_decoder_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] instr_word,
    input wire logic skip_true,
    input wire logic cycle_en,
    input wire logic exec_nop,
    input wire logic second_word,
    input wire logic dest_file,
    input wire logic access_banked,
    input wire logic [7:0] file_addr,
    input wire logic [2:0] bit_num,
    input wire logic [7:0] bit_mask,
    input wire logic [11:0] move_src,
    input wire logic [11:0] move_dst,
    input wire logic [10:0] branch_offset,
    input wire logic [5:0] alu_op,
    input wire logic is_skip,
    input wire logic [1:0] cycle_count
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // The first word of a file-to-file move, then its tagged second word.
    sequence s_move_first;
        cycle_en && instr_word[15:12] == 4'hC;
    endsequence
    sequence s_tail_word;
        cycle_en && instr_word[15:12] == 4'hF;
    endsequence
    // A decoded skip form whose condition the datapath reports true one clock later.
    sequence s_skip_taken;
        cycle_en ##1 (is_skip && skip_true);
    endsequence
    property p_skip;
        s_skip_taken |=> cycle_count == 2'h2;
    endproperty
    property p_cycle;
        cycle_en |=> !cycle_en [*3] ##1 cycle_en;
    endproperty
    property p_dest;
        cycle_en && instr_word[15:12] inside {[4'h1:4'h5]} |-> ##2
            dest_file == $past(instr_word[9], 2) && file_addr == $past(instr_word[7:0], 2);
    endproperty
    property p_access;
        cycle_en && instr_word[15:12] inside {[4'h1:4'hB]} |-> ##2
            access_banked == $past(instr_word[8], 2);
    endproperty
    property p_bit;
        cycle_en && instr_word[15:12] inside {[4'h7:4'hB]} |-> ##2
            bit_num == $past(instr_word[11:9], 2) && $onehot(bit_mask) && bit_mask[bit_num];
    endproperty
    property p_two;
        s_move_first |-> ##2 (cycle_count == 2'h2) [*3];
    endproperty
    property p_second;
        s_move_first ##4 s_tail_word |-> ##2 exec_nop && second_word
            && move_dst == $past(instr_word[11:0], 2) && move_src == $past(instr_word[11:0], 6);
    endproperty
    property p_branch;
        cycle_en && instr_word[15:11] == 5'h1A |-> ##2
            branch_offset == $past(instr_word[10:0], 2) && cycle_count == 2'h2;
    endproperty
    // A plain byte operation that neither skips nor jumps stays a single cycle.
    property p_single;
        cycle_en ##2 (alu_op != 6'd0 && alu_op < 6'd31 && !is_skip) |->
            cycle_count == 2'h1 ##1 cycle_count == 2'h1;
    endproperty
    a_cycle: assert property (p_cycle) else $error("cycle strobe spacing wrong");
    a_dest: assert property (p_dest) else $error("byte fields wrong");
    a_access: assert property (p_access) else $error("access bit wrong");
    a_bit: assert property (p_bit) else $error("bit number wrong");
    a_two: assert property (p_two) else $error("two-word length wrong");
    a_second: assert property (p_second) else $error("second word wrong");
    a_branch: assert property (p_branch) else $error("branch decode wrong");
    a_single: assert property (p_single) else $error("single cycle wrong");
    a_skip: assert property (p_skip) else $error("skip extension missing");
endmodule // bod_decoder_checker
bind bod_decoder bod_decoder_checker chk (.clk, .rstn, .instr_word, .skip_true, .cycle_en, .exec_nop,
    .second_word, .dest_file, .access_banked, .file_addr, .bit_num, .bit_mask, .move_src,
    .move_dst, .branch_offset, .alu_op, .is_skip, .cycle_count);
`default_nettype wire

// ==== bod_defs.vh ====
// Constants for the byte-operation instruction decoder.
`ifndef BOD_DEFS_VH
`define BOD_DEFS_VH
`define BOD_OSC_PER_CYCLE 4
`define BOD_SECOND_WORD_TAG 4'hF
`define BOD_MOVE_FF_OP 4'hC
`define BOD_GOTO_OP 8'hEF
`define BOD_CALL_OP 7'h76
`define BOD_LFSR_OP 10'h3B8
`define BOD_RBRANCH_OP 5'h1A
`define BOD_TABLE_OP 12'h000
`define BOD_TABLE_RD 2'h2
`define BOD_TABLE_WT 2'h3
`define BOD_RETURN_OP 15'h0009
`define BOD_FLAG_C 0
`define BOD_FLAG_DC 1
`define BOD_FLAG_Z 2
`define BOD_FLAG_OV 3
`define BOD_FLAG_N 4
`define BOD_FLAGS_ALL 5'h1F
`define BOD_FLAGS_ZN 5'h14
`define BOD_FLAGS_CZN 5'h15
`define BOD_FLAGS_Z 5'h04
`define BOD_FLAGS_NONE 5'h00
`endif

// ==== bod_fetch_model.sv ====
// Program memory fetch model that hands the decoder one word per instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module bod_fetch_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cycle_en,
    output logic [15:0] instr_word
);
    logic [15:0] mem [0:15];
    logic [3:0] ptr_reg;
    // Outside the fetch slot the bus shows the inverse, so a stray sample cannot pass.
    assign instr_word = cycle_en ? mem[ptr_reg] : ~mem[ptr_reg];
    // Each word occupies one slot; a two-word instruction spends two slots.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_reg <= 4'h0;
        end else if (cycle_en) begin
            ptr_reg <= ptr_reg + 4'h1;
        end
    end
endmodule // bod_fetch_model
`default_nettype wire

// ==== bod_tb.sv ====
// Self-checking bench for the decoder, fed by the fetch model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons = comparisons + 1; if ((a) !== (e)) begin \
    n_fail = n_fail + 1; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    localparam [239:0] OPS = 240'h2420_5C58_5414_1018_1C62_6460_6A68_6C6E_6602_0428_2C4C_3C48_3444_3040_3850;
    localparam [31:0] SKIPS = 32'h01E2_1C00;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg skip_true = 1'b0;
    integer n_fail;
    integer comparisons;
    integer i;
    wire cycle_en, exec_nop, second_word, dest_file, access_banked, fast_mode;
    wire table_op, table_write, is_skip;
    wire [15:0] instr_word, instr_reg;
    wire [5:0] byte_opcode, alu_op;
    wire [7:0] file_addr, bit_mask, literal;
    wire [2:0] bit_num;
    wire [19:0] jump_target;
    wire [11:0] move_src, move_dst;
    wire [10:0] branch_offset;
    wire [4:0] flag_mask;
    wire [1:0] table_mode, cycle_count, phase;
    bod_fetch_model fetch (.clk, .rstn, .cycle_en, .instr_word);
    bod_decoder dut (.clk, .rstn, .instr_word, .skip_true, .cycle_en, .phase, .instr_reg,
        .exec_nop, .second_word, .byte_opcode, .dest_file, .access_banked, .file_addr, .bit_num,
        .bit_mask, .literal, .jump_target, .move_src, .move_dst, .branch_offset, .fast_mode,
        .table_op, .table_write, .table_mode, .alu_op, .flag_mask, .is_skip, .cycle_count);
    // A 20 MHz clock.
    initial begin
        forever #25 clk = ~clk;
    end
    task test_done;
        begin
            if (n_fail == 0 && comparisons > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // Waits for the fetch slot, places the word, and returns once decode has settled.
    task take(input [15:0] w, input s);
        integer k;
        begin
            k = 0;
            do begin
                @(posedge clk) skip_true <= s;
                @(negedge clk);
                k = k + 1;
            end while (cycle_en !== 1'b1 && k < 8);
            if (cycle_en !== 1'b1) begin
                n_fail = n_fail + 1;
                test_done;
            end else begin
                fetch.mem[fetch.ptr_reg] = w;
                repeat (2) @(negedge clk);
                `CHK(instr_reg, w)
                `CHK(phase, 2'h2)
            end
        end
    endtask
    // Flags each operation touches; everything else must be held by the datapath.
    function [4:0] fmask(input integer c);
        begin
            case (c)
                1, 2, 3, 4, 5, 15, 19, 20: fmask = 5'h1F;
                6, 7, 8, 9, 26, 28, 30: fmask = 5'h14;
                13: fmask = 5'h04;
                25, 27: fmask = 5'h15;
                default: fmask = 5'h00;
            endcase
        end
    endfunction
    // Every byte-oriented opcode; each skip form is driven once, taken if its loop index is odd and not taken if it is even.
    task t_byte_ops;
        begin
            for (i = 0; i < 30; i = i + 1) begin
                take({OPS[239 - 8 * i -: 8], i[7:0]}, i[0]);
                `CHK(alu_op, i[5:0] + 6'd1)
                `CHK(flag_mask, fmask(i + 1))
                `CHK(is_skip, SKIPS[i + 1])
                `CHK(byte_opcode, OPS[239 - 8 * i -: 6])
                `CHK(exec_nop, 1'b0)
                @(negedge clk);
                `CHK(cycle_count, (SKIPS[i + 1] && i[0]) ? 2'h2 : 2'h1)
            end
        end
    endtask
    // Destination, access and bit-number fields over all their values.
    task t_fields;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                take({6'h09, i[1:0], 8'h5A}, 1'b0);
                `CHK(dest_file, i[1])
                `CHK(access_banked, i[0])
            end
            for (i = 0; i < 8; i = i + 1) begin
                take({4'h9, i[2:0], 1'b1, 8'h3C}, 1'b0);
                `CHK(bit_num, i[2:0])
                `CHK(bit_mask, 8'h01 << i)
            end
            take(16'h0E7F, 1'b0);
            `CHK(literal, 8'h7F)
        end
    endtask
    // Jump, call and file move, each followed by its second word, then a lone tagged word.
    task t_two_word;
        begin
            take(16'hEF12, 1'b0);
            `CHK(alu_op, 6'd32)
            `CHK(cycle_count, 2'h2)
            take(16'hF345, 1'b0);
            `CHK(second_word, 1'b1)
            `CHK(jump_target, 20'h3_4512)
            take(16'hED34, 1'b0);
            `CHK(fast_mode, 1'b1)
            take(16'hFABC, 1'b0);
            `CHK(jump_target, 20'hA_BC34)
            take(16'hEE15, 1'b0);
            `CHK(alu_op, 6'd37)
            `CHK(cycle_count, 2'h2)
            take(16'hF0AB, 1'b0);
            `CHK(second_word, 1'b1)
            `CHK(exec_nop, 1'b1)
            take(16'hC123, 1'b0);
            `CHK(move_src, 12'h123)
            take(16'hF456, 1'b0);
            `CHK(move_dst, 12'h456)
            `CHK(exec_nop, 1'b1)
            take(16'hF0F0, 1'b0);
            `CHK(exec_nop, 1'b1)
            `CHK(cycle_count, 2'h1)
        end
    endtask
    // Relative branch, all table modes and both return modes.
    task t_control;
        begin
            take(16'hD5AB, 1'b0);
            `CHK(branch_offset, 11'h5AB)
            `CHK(cycle_count, 2'h2)
            for (i = 0; i < 8; i = i + 1) begin
                take({12'h000, 1'b1, i[2:0]}, 1'b0);
                `CHK({table_op, table_write, table_mode}, {1'b1, i[2:0]})
            end
            take(16'h0013, 1'b0);
            `CHK(fast_mode, 1'b1)
            take(16'h0012, 1'b0);
            `CHK(fast_mode, 1'b0)
        end
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial begin
        n_fail = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        `CHK({cycle_en, exec_nop, cycle_count}, 4'h5)
        @(posedge clk) rstn <= 1'b1;
        t_byte_ops;
        t_fields;
        t_two_word;
        t_control;
        test_done;
    end
endmodule // testbench
`default_nettype wire
